// >>> tbs_pkg.sv
// Constants shared by the triple converter fault supervisor
package tbs_pkg;
    // Clock rate and documented times
    localparam int unsigned CLK_KHZ = 40000;
    localparam int unsigned OC_TIME_MS = 10;
    localparam int unsigned RETRY_TIME_MS = 10;
    localparam int unsigned POK_DELAY_MS = 100;
    localparam int unsigned OC_CYC = OC_TIME_MS * CLK_KHZ;
    localparam int unsigned RETRY_CYC = RETRY_TIME_MS * CLK_KHZ;
    localparam int unsigned POK_CYC = POK_DELAY_MS * CLK_KHZ;
    // Switching clock half period in pclk cycles
    localparam int unsigned SW_HALF_CYC = 20;
    localparam int unsigned NUM_CONV = 3;
    localparam int unsigned NUM_PORT = 2;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] STATUS_OFF = 8'h04;
    localparam logic [7:0] HICCUP_CNT_OFF = 8'h08;

    // Control fields
    localparam int unsigned CTRL_HOLD_BIT = 0;
    localparam int unsigned CTRL_PORT_BLOCK_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    // Status fields
    localparam int unsigned ST_STATE_LSB = 0;
    localparam int unsigned ST_POK_BIT = 2;
    localparam int unsigned ST_RUN_LSB = 4;
    localparam int unsigned ST_HS_LSB = 8;
    localparam int unsigned ST_PFAULT_LSB = 12;
    localparam int unsigned ST_SKIP_LSB = 16;

    typedef enum logic [1:0] {
        TBS_RUN = 2'b00,
        TBS_HICCUP = 2'b01,
        TBS_THERMAL = 2'b10
    } tbs_state_t;
endpackage

// >>> tbs_rail.sv
// One converter: run control, overcurrent timing and overshoot guard
`timescale 1ns/100ps
module tbs_rail #(
    parameter int unsigned OC_CYC = tbs_pkg::OC_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hold_off,
    input wire logic converter_enable,
    input wire logic overcurrent,
    input wire logic fb_above_guard,
    input wire logic fb_below_release,
    input wire logic sw_tick,
    output logic run,
    output logic hs_allow,
    output logic long_fault
);
    logic [31:0] oc_cnt_q, oc_cnt_d;
    logic run_q, run_d;
    logic hs_q, hs_d;
    logic lf_q, lf_d;

    if (OC_CYC < 2)
        $error("OC_CYC must be at least 2");

    always_comb
    begin
        oc_cnt_d = 32'h0;
        lf_d = 1'b0;
        if (overcurrent && !hold_off)
        begin
            oc_cnt_d = (oc_cnt_q == OC_CYC) ? oc_cnt_q : oc_cnt_q + 32'h1;
            lf_d = (oc_cnt_q == OC_CYC - 1);
        end
        run_d = converter_enable & ~hold_off & ~overcurrent;
        hs_d = hs_q;
        if (fb_above_guard)
            hs_d = 1'b0;
        else if (!hs_q && fb_below_release && sw_tick)
            hs_d = 1'b1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            oc_cnt_q <= 32'h0;
            run_q <= 1'b0;
            hs_q <= 1'b1;
            lf_q <= 1'b0;
        end
        else
        begin
            oc_cnt_q <= oc_cnt_d;
            run_q <= run_d;
            hs_q <= hs_d;
            lf_q <= lf_d;
        end
    end

    assign run = run_q;
    assign hs_allow = hs_q;
    assign long_fault = lf_q;
endmodule

// >>> tbs_supervisor.sv
// Top of the triple converter fault supervisor with APB registers
//
// Overview of operation
// - Overcurrent over 10 ms on any converter: all off 10 ms, then restart.
// - Shorter overload restarts only the affected converter.
// - Feedback above 106 percent holds that high-side switch off.
// - Below 104 percent, high-side switch allowed from next switching tick.
// - Power ok only after start-up sequencing completes.
// - Power ok low when any output below 85 percent.
// - Power ok released only when all outputs above 90 percent; the code checks this only when the delay count starts.
// - Power ok release delayed by 100 ms.
// - Power ok is active high.
// - Switch overcurrent or short: constant-current limiting, fault flag low.
// - Switch thermal warning turns that switch off; converters keep running.
// - Die above 160 C stops all operation.
// - Below 140 C after shutdown, full power-up restarts.
// - Converter switching clocks run 180 degrees apart; the code runs converters 0 and 2 in phase and converter 1 opposite.
// - Light load skip automatic unless forced fixed switching selected.
// - Port fault flag low on switch overcurrent or overtemperature.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module tbs_supervisor #(
    parameter int unsigned OC_CYC = tbs_pkg::OC_CYC,
    parameter int unsigned RETRY_CYC = tbs_pkg::RETRY_CYC,
    parameter int unsigned POK_CYC = tbs_pkg::POK_CYC,
    parameter int unsigned SW_HALF_CYC = tbs_pkg::SW_HALF_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [2:0] converter_enable,
    input wire logic [2:0] conv_overcurrent,
    input wire logic [2:0] fb_above_guard,
    input wire logic [2:0] fb_below_release,
    input wire logic [2:0] rail_below_85,
    input wire logic [2:0] rail_above_90,
    input wire logic [2:0] light_load_detect,
    input wire logic force_fixed_switching,
    input wire logic die_above_160,
    input wire logic die_below_140,
    input wire logic [1:0] port_switch_enable,
    input wire logic [1:0] port_overcurrent,
    input wire logic [1:0] port_thermal_warn,
    output logic [2:0] conv_run,
    output logic [2:0] conv_hs_allow,
    output logic [2:0] conv_phase_clk,
    output logic [2:0] light_load_skip,
    output logic power_ok_flag,
    output logic [1:0] port_switch_on,
    output logic [1:0] port_current_limit,
    output logic [1:0] port_fault_n
);
    tbs_pkg::tbs_state_t state_q, state_d;
    logic [31:0] wait_q, wait_d;
    logic [31:0] pok_cnt_q, pok_cnt_d;
    logic pok_q, pok_d;
    logic [15:0] sw_cnt_q, sw_cnt_d;
    logic [2:0] ph_q, ph_d;
    logic tick_q, tick_d;
    logic [2:0] skip_q, skip_d;
    logic [1:0] psw_q, psw_d;
    logic [1:0] plim_q, plim_d;
    logic [1:0] pflt_n_q, pflt_n_d;
    logic [1:0] ctrl_q, ctrl_d;
    logic [15:0] hic_cnt_q, hic_cnt_d;
    logic [31:0] rdata_q, rdata_d;
    logic rdy_q, rdy_d;
    logic err_q, err_d;
    logic hold_off;
    logic [2:0] run_w, hs_w, lf_w;
    logic seq_done;

    if (OC_CYC < 2 || RETRY_CYC < 1 || POK_CYC < 1)
        $error("Timing counts must be positive");
    if (SW_HALF_CYC < 1 || SW_HALF_CYC > 65535)
        $error("SW_HALF_CYC out of range");

    assign hold_off = (state_q != tbs_pkg::TBS_RUN) | ctrl_q[tbs_pkg::CTRL_HOLD_BIT];

    for (genvar i = 0; i < 3; i++)
    begin : g_rail
        tbs_rail #(
            .OC_CYC(OC_CYC)
        ) u_rail (
            .pclk(pclk),
            .presetn(presetn),
            .hold_off(hold_off),
            .converter_enable(converter_enable[i]),
            .overcurrent(conv_overcurrent[i]),
            .fb_above_guard(fb_above_guard[i]),
            .fb_below_release(fb_below_release[i]),
            .sw_tick(tick_q),
            .run(run_w[i]),
            .hs_allow(hs_w[i]),
            .long_fault(lf_w[i])
        );
    end

    assign conv_run = run_w;
    assign conv_hs_allow = hs_w;

    // Supervisor state and fault timers
    always_comb
    begin
        state_d = state_q;
        wait_d = 32'h0;
        hic_cnt_d = hic_cnt_q;
        case (state_q)
            tbs_pkg::TBS_RUN:
            begin
                if (|lf_w)
                begin
                    state_d = tbs_pkg::TBS_HICCUP;
                    hic_cnt_d = hic_cnt_q + 16'h1;
                end
            end
            tbs_pkg::TBS_HICCUP:
            begin
                wait_d = wait_q + 32'h1;
                if (wait_q == RETRY_CYC - 1)
                    state_d = tbs_pkg::TBS_RUN;
            end
            tbs_pkg::TBS_THERMAL:
            begin
                if (die_below_140 && !die_above_160)
                    state_d = tbs_pkg::TBS_RUN;
            end
            default:
                state_d = tbs_pkg::TBS_RUN;
        endcase
        if (die_above_160)
        begin
            state_d = tbs_pkg::TBS_THERMAL;
            wait_d = 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= tbs_pkg::TBS_RUN;
            wait_q <= 32'h0;
            hic_cnt_q <= 16'h0;
        end
        else
        begin
            state_q <= state_d;
            wait_q <= wait_d;
            hic_cnt_q <= hic_cnt_d;
        end
    end

    // Power ok supervisor
    assign seq_done = (state_q == tbs_pkg::TBS_RUN) & (&run_w);

    always_comb
    begin
        pok_cnt_d = pok_cnt_q;
        pok_d = pok_q;
        if (!seq_done || (|rail_below_85))
        begin
            pok_cnt_d = 32'h0;
            pok_d = 1'b0;
        end
        // Start counting when all above 90, then keep counting once started
        else if (!pok_q && (pok_cnt_q != 32'h0 || (&rail_above_90)))
        begin
            pok_cnt_d = pok_cnt_q + 32'h1;
            if (pok_cnt_q == POK_CYC - 1)
            begin
                pok_d = 1'b1;
                pok_cnt_d = 32'h0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pok_cnt_q <= 32'h0;
            pok_q <= 1'b0;
        end
        else
        begin
            pok_cnt_q <= pok_cnt_d;
            pok_q <= pok_d;
        end
    end

    assign power_ok_flag = pok_q;

    // Switching clock, phases and skip selection
    always_comb
    begin
        sw_cnt_d = sw_cnt_q + 16'h1;
        ph_d = ph_q;
        tick_d = 1'b0;
        if (sw_cnt_q == 16'(SW_HALF_CYC - 1))
        begin
            sw_cnt_d = 16'h0;
            ph_d = ~ph_q;
            tick_d = ~ph_q[0];
        end
        skip_d = light_load_detect & run_w & {3{~force_fixed_switching}};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sw_cnt_q <= 16'h0;
            ph_q <= 3'h2;
            tick_q <= 1'b0;
            skip_q <= 3'h0;
        end
        else
        begin
            sw_cnt_q <= sw_cnt_d;
            ph_q <= ph_d;
            tick_q <= tick_d;
            skip_q <= skip_d;
        end
    end

    assign conv_phase_clk = ph_q;
    assign light_load_skip = skip_q;

    // Port load switches
    always_comb
    begin
        psw_d = port_switch_enable & ~port_thermal_warn;
        if (state_q == tbs_pkg::TBS_THERMAL || ctrl_q[tbs_pkg::CTRL_PORT_BLOCK_BIT])
            psw_d = 2'h0;
        plim_d = psw_d & port_overcurrent;
        pflt_n_d = ~(port_overcurrent | port_thermal_warn);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            psw_q <= 2'h0;
            plim_q <= 2'h0;
            pflt_n_q <= 2'h3;
        end
        else
        begin
            psw_q <= psw_d;
            plim_q <= plim_d;
            pflt_n_q <= pflt_n_d;
        end
    end

    assign port_switch_on = psw_q;
    assign port_current_limit = plim_q;
    assign port_fault_n = pflt_n_q;

    // APB slave, answers in the first access cycle
    always_comb
    begin
        ctrl_d = ctrl_q;
        rdy_d = psel & ~penable;
        rdata_d = rdata_q;
        err_d = 1'b0;
        if (psel && !penable)
        begin
            rdata_d = 32'h0;
            case (paddr)
                tbs_pkg::CTRL_OFF:
                    rdata_d[1:0] = ctrl_q;
                tbs_pkg::STATUS_OFF:
                begin
                    rdata_d[tbs_pkg::ST_STATE_LSB +: 2] = state_q;
                    rdata_d[tbs_pkg::ST_POK_BIT] = pok_q;
                    rdata_d[tbs_pkg::ST_RUN_LSB +: 3] = run_w;
                    rdata_d[tbs_pkg::ST_HS_LSB +: 3] = hs_w;
                    rdata_d[tbs_pkg::ST_PFAULT_LSB +: 2] = ~pflt_n_q;
                    rdata_d[tbs_pkg::ST_SKIP_LSB +: 3] = skip_q;
                end
                tbs_pkg::HICCUP_CNT_OFF:
                    rdata_d[15:0] = hic_cnt_q;
                default:
                    err_d = 1'b1;
            endcase
            if (pwrite)
                rdata_d = 32'h0;
            if (pwrite && paddr != tbs_pkg::CTRL_OFF)
                err_d = 1'b1;
        end
        if (psel && penable && rdy_q && pwrite && paddr == tbs_pkg::CTRL_OFF)
            ctrl_d = pwdata[1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= tbs_pkg::CTRL_RESET;
            rdata_q <= 32'h0;
            rdy_q <= 1'b0;
            err_q <= 1'b0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            rdata_q <= rdata_d;
            rdy_q <= rdy_d;
            err_q <= err_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
endmodule

// >>> tbs_power_stage.sv
// Behavioural model of the converter outputs and feedback comparators
`timescale 1ns/100ps
module tbs_power_stage (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] conv_run,
    input wire logic [2:0] sag,
    input wire logic [2:0] overshoot,
    output logic [2:0] rail_below_85,
    output logic [2:0] rail_above_90,
    output logic [2:0] fb_above_guard,
    output logic [2:0] fb_below_release
);
    int lvl [3];
    // Output ramps up while running, collapses when stopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (!presetn || !conv_run[i])
                lvl[i] <= 0;
            else if (sag[i])
                lvl[i] <= 80;
            else if (lvl[i] < 100)
                lvl[i] <= lvl[i] + 10;
        end
        fb_below_release <= presetn ? ~overshoot : 3'h7;
    end
    always_comb
    begin
        for (int i = 0; i < 3; i++)
        begin
            rail_below_85[i] = lvl[i] < 85;
            rail_above_90[i] = lvl[i] > 90;
        end
        fb_above_guard = overshoot;
    end
endmodule

// >>> tbs_supervisor_asserts.sv
// Port checker for the triple converter fault supervisor
`timescale 1ns/100ps
module tbs_supervisor_asserts #(
    parameter int unsigned POK_CYC = 30
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] conv_overcurrent,
    input wire logic [2:0] fb_above_guard,
    input wire logic [2:0] rail_below_85,
    input wire logic [2:0] light_load_detect,
    input wire logic force_fixed_switching,
    input wire logic die_above_160,
    input wire logic [1:0] port_overcurrent,
    input wire logic [1:0] port_thermal_warn,
    input wire logic [2:0] conv_run,
    input wire logic [2:0] conv_hs_allow,
    input wire logic [2:0] conv_phase_clk,
    input wire logic [2:0] light_load_skip,
    input wire logic power_ok_flag,
    input wire logic [1:0] port_switch_on,
    input wire logic [1:0] port_current_limit,
    input wire logic [1:0] port_fault_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    int good_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            good_q <= 0;
        else if (&conv_run && !(|rail_below_85))
            good_q <= good_q + 1;
        else
            good_q <= 0;
    end
    sequence s_die_hot;
        die_above_160;
    endsequence
    sequence s_all_off;
        conv_run == 3'h0 && port_switch_on == 2'h0;
    endsequence
    property p_oc_off;
        conv_overcurrent[0] |=> !conv_run[0];
    endproperty
    a_oc_off: assert property (p_oc_off) else $error("run kept during overcurrent");
    property p_guard;
        fb_above_guard[1] |=> !conv_hs_allow[1];
    endproperty
    a_guard: assert property (p_guard) else $error("high side kept during overshoot");
    property p_pok_low;
        |rail_below_85 |=> !power_ok_flag;
    endproperty
    a_pok_low: assert property (p_pok_low) else $error("power ok high with low rail");
    property p_pok_delay;
        $rose(power_ok_flag) |-> good_q >= POK_CYC - 2 && $past(&conv_run);
    endproperty
    a_pok_delay: assert property (p_pok_delay) else $error("power ok released early");
    property p_port_flag;
        |port_overcurrent ##1 port_current_limit[0] |-> !port_fault_n[0];
    endproperty
    a_port_flag: assert property (p_port_flag) else $error("limit without fault flag");
    property p_port_warn;
        port_thermal_warn[1] |=> !port_switch_on[1] && !port_fault_n[1];
    endproperty
    a_port_warn: assert property (p_port_warn) else $error("switch on during warning");
    property p_thermal;
        s_die_hot |=> ##1 s_all_off;
    endproperty
    a_thermal: assert property (p_thermal) else $error("running while too hot");
    property p_phase;
        !(conv_phase_clk[0] && conv_phase_clk[1]) && conv_phase_clk[2] == conv_phase_clk[0];
    endproperty
    a_phase: assert property (p_phase) else $error("switching clocks not in antiphase");
    property p_skip;
        force_fixed_switching |=> light_load_skip == 3'h0;
    endproperty
    a_skip: assert property (p_skip) else $error("skip while fixed forced");
endmodule
bind tbs_supervisor tbs_supervisor_asserts #(.POK_CYC(POK_CYC)) chk (.pclk(pclk),
    .presetn(presetn), .conv_overcurrent(conv_overcurrent), .fb_above_guard(fb_above_guard),
    .rail_below_85(rail_below_85), .light_load_detect(light_load_detect),
    .force_fixed_switching(force_fixed_switching), .die_above_160(die_above_160),
    .port_overcurrent(port_overcurrent), .port_thermal_warn(port_thermal_warn),
    .conv_run(conv_run), .conv_hs_allow(conv_hs_allow), .conv_phase_clk(conv_phase_clk),
    .light_load_skip(light_load_skip), .power_ok_flag(power_ok_flag),
    .port_switch_on(port_switch_on), .port_current_limit(port_current_limit),
    .port_fault_n(port_fault_n));

// >>> tbs_supervisor_bench.sv
// Self-checking bench for the triple converter fault supervisor
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("BAD %s exp %0h got %0h", n, e, g); end end
module tbs_supervisor_bench;
    localparam int OC = 20, RT = 16, PK = 30, SW = 4;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, e, force_fixed_switching = 0, die_above_160 = 0;
    logic die_below_140 = 1;
    logic [2:0] converter_enable = 0, conv_overcurrent = 0, light_load_detect = 0;
    logic [2:0] sag = 0, overshoot = 0, rb85, ra90, fag, fbr, run, hs, ph, skip;
    logic [1:0] port_switch_enable = 0, port_overcurrent = 0, port_thermal_warn = 0;
    logic [1:0] pon, plim, pfn;
    logic pok;
    int errors = 0, n_tests = 0, k;
    always #12.5 pclk = ~pclk;
    tbs_supervisor #(.OC_CYC(OC), .RETRY_CYC(RT), .POK_CYC(PK), .SW_HALF_CYC(SW)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .converter_enable(converter_enable), .conv_overcurrent(conv_overcurrent),
        .fb_above_guard(fag), .fb_below_release(fbr), .rail_below_85(rb85),
        .rail_above_90(ra90), .light_load_detect(light_load_detect),
        .force_fixed_switching(force_fixed_switching), .die_above_160(die_above_160),
        .die_below_140(die_below_140), .port_switch_enable(port_switch_enable),
        .port_overcurrent(port_overcurrent), .port_thermal_warn(port_thermal_warn),
        .conv_run(run), .conv_hs_allow(hs), .conv_phase_clk(ph), .light_load_skip(skip),
        .power_ok_flag(pok), .port_switch_on(pon), .port_current_limit(plim),
        .port_fault_n(pfn));
    tbs_power_stage stage (.pclk(pclk), .presetn(presetn), .conv_run(run), .sag(sag),
        .overshoot(overshoot), .rail_below_85(rb85), .rail_above_90(ra90),
        .fb_above_guard(fag), .fb_below_release(fbr));
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata; e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic wait_pok(output int n);
        n = 0;
        while (pok !== 1'b1 && n < 200)
        begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic t_regs;
        apb(0, tbs_pkg::CTRL_OFF, 0); `CHK("ctrl reset", 32'h0, r)
        apb(1, tbs_pkg::CTRL_OFF, 32'h3); apb(0, tbs_pkg::CTRL_OFF, 0);
        `CHK("ctrl rw", 32'h3, r)
        `CHK("hold runs", 3'h0, run)
        `CHK("block ports", 2'h0, pon)
        apb(1, tbs_pkg::CTRL_OFF, 0);
        apb(0, 8'h0c, 0); `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0, r)
        apb(1, tbs_pkg::STATUS_OFF, 32'h7); `CHK("ro err", 1'b1, e)
        $display("done regs");
    endtask
    task automatic t_pok;
        cyc(3); `CHK("pok before ramp", 1'b0, pok)
        wait_pok(k); `CHK("pok delay", 1'b1, k >= PK && k < PK + 20)
        sag <= 3'h4; cyc(3); `CHK("pok sag", 1'b0, pok)
        sag <= 3'h0; wait_pok(k); `CHK("pok back", 1'b1, pok)
        $display("done pok");
    endtask
    task automatic t_short;
        conv_overcurrent <= 3'h2; cyc(5);
        `CHK("short only one", 3'h5, run)
        conv_overcurrent <= 3'h0; cyc(3); `CHK("short back", 3'h7, run)
        apb(0, tbs_pkg::HICCUP_CNT_OFF, 0); `CHK("no hiccup", 32'h0, r)
        $display("done short");
    endtask
    task automatic t_long;
        conv_overcurrent <= 3'h1; cyc(OC + 5);
        `CHK("hiccup all off", 3'h0, run)
        apb(0, tbs_pkg::STATUS_OFF, 0); `CHK("hiccup state", 2'h1, r[1:0])
        cyc(RT + OC + 2); apb(0, tbs_pkg::HICCUP_CNT_OFF, 0);
        `CHK("hiccup repeat", 32'h2, r)
        conv_overcurrent <= 3'h0; cyc(RT + 4);
        `CHK("retry run", 3'h7, run)
        apb(0, tbs_pkg::HICCUP_CNT_OFF, 0); `CHK("hiccup count", 32'h2, r)
        wait_pok(k);
        $display("done long");
    endtask
    task automatic t_guard;
        logic [2:0] p;
        overshoot <= 3'h2; cyc(3); `CHK("guard off", 3'h5, hs)
        overshoot <= 3'h0; cyc(4 * SW + 4); `CHK("guard on", 3'h7, hs)
        p = ph; cyc(SW); `CHK("phase half", ~p, ph)
        `CHK("antiphase", 3'h2, ph ^ {3{ph[0]}})
        $display("done guard");
    endtask
    task automatic t_ports;
        port_overcurrent <= 2'h1; port_thermal_warn <= 2'h2; cyc(3);
        `CHK("limit", 2'h1, plim)
        `CHK("fault flags", 2'h0, pfn)
        `CHK("warn off", 2'h1, pon)
        `CHK("conv keep", 3'h7, run)
        port_overcurrent <= 2'h0; port_thermal_warn <= 2'h0; cyc(3);
        `CHK("flags clear", 2'h3, pfn)
        $display("done ports");
    endtask
    task automatic t_thermal;
        die_above_160 <= 1; die_below_140 <= 0; cyc(3);
        `CHK("hot stop", 3'h0, run)
        `CHK("hot ports", 2'h0, pon)
        die_above_160 <= 0; cyc(3); `CHK("between", 3'h0, run)
        die_below_140 <= 1; cyc(3); `CHK("restart", 3'h7, run)
        `CHK("restart pok", 1'b0, pok)
        wait_pok(k); `CHK("pok again", 1'b1, pok)
        $display("done thermal");
    endtask
    task automatic t_skip;
        light_load_detect <= 3'h5; cyc(3); `CHK("skip auto", 3'h5, skip)
        force_fixed_switching <= 1; cyc(3); `CHK("skip forced", 3'h0, skip)
        force_fixed_switching <= 0; light_load_detect <= 3'h0;
        $display("done skip");
    endtask
    task automatic summarize;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        cyc(6);
        presetn <= 1;
        converter_enable <= 3'h7; port_switch_enable <= 2'h3;
        t_regs;
        t_pok;
        t_short;
        t_long;
        t_guard;
        t_ports;
        t_thermal;
        t_skip;
        summarize;
    end
    initial
    begin
        cyc(5000);
        errors++;
        summarize;
    end
endmodule
